// ---- hw/cwr_params.svh ----
`ifndef CWR_PARAMS_SVH
`define CWR_PARAMS_SVH

// system register offsets (bank 0)
`define CWR_OFS_LOOKUP_HIGH   8'h82
`define CWR_OFS_POINTER_LOW   8'h83
`define CWR_OFS_POINTER_BANK  8'h84
`define CWR_OFS_PROGRAM_FLAGS 8'h86
`define CWR_OFS_PC_LOWER      8'hce
`define CWR_OFS_PC_UPPER      8'hcf
`define CWR_OFS_INDIRECT      8'he7

// immediate-to-ram window (working registers)
`define CWR_IMM_WIN_LO        8'h80
`define CWR_IMM_WIN_HI        8'h87

// program_flags field positions
`define CWR_BIT_CAUSE_HI      7
`define CWR_BIT_CAUSE_LO      6
`define CWR_BIT_SUPPLY_HIGH   5
`define CWR_BIT_SUPPLY_MID    4
`define CWR_BIT_CARRY         2
`define CWR_BIT_HALF_CARRY    1
`define CWR_BIT_ZERO          0

// software-writable bits of program_flags
`define CWR_FLAGS_WR_MASK     8'hc7

// reset values
`define CWR_RST_BYTE          8'h00
`define CWR_RST_PC            11'h000

// program counter steps
`define CWR_PC_STEP           11'h001
`define CWR_PC_SKIP           11'h002

`endif

// ---- hw/cwr_pkg.sv ----
package cwr_pkg;

  // decoded operation, driven by the instruction decoder
  typedef enum logic [4:0] {
    CWR_OP_NOP   = 5'h00,
    CWR_OP_MOV   = 5'h01,
    CWR_OP_ADD   = 5'h02,
    CWR_OP_ADC   = 5'h03,
    CWR_OP_SUB   = 5'h04,
    CWR_OP_SBC   = 5'h05,
    CWR_OP_AND   = 5'h06,
    CWR_OP_OR    = 5'h07,
    CWR_OP_XOR   = 5'h08,
    CWR_OP_RLC   = 5'h09,
    CWR_OP_RRC   = 5'h0a,
    CWR_OP_COMPARE_SKIP_INSTR = 5'h0b,
    CWR_OP_INC_ACC_SKIP_INSTR  = 5'h0c,
    CWR_OP_DEC_ACC_SKIP_INSTR  = 5'h0d,
    CWR_OP_BIT_CLEAR_SKIP_INSTR  = 5'h0e,
    CWR_OP_BIT_SET_SKIP_INSTR  = 5'h0f,
    CWR_OP_JUMP  = 5'h10,
    CWR_OP_ROM_LOOKUP_INSTR  = 5'h11,
    CWR_OP_SAVE  = 5'h12,
    CWR_OP_LOAD  = 5'h13
  } cwr_op_type;

endpackage

// ---- hw/cwr_core.sv ----
// What this block does
// - accumulator sits outside the data memory map
// - carry, half carry, zero in flag bits 2..0
// - save and restore copy accumulator and flags
// - flag bits 7:6 record last reset cause
// - bit 5 shows supply at/below high level
// - bit 4 shows supply at/below mid level
// - carry follows add, subtract, rotate, compare
// - half carry follows low nibble carry
// - zero flag marks a zero result
// - 11-bit counter, cleared at reset, counts up
// - jump loads full 11-bit target
// - true skip condition advances counter by two
// - bit test and compare decide skips
// - increment skips on wrap to zero
// - decrement skips on wrap to all ones
// - add into pc_lower carries into pc_upper
// - borrow from pc_lower leaves pc_upper alone
// - move into pc_lower jumps within page
// - pointer pair addresses ram bank and location
// - rom lookup splits word into register and accumulator
// - immediate writes only reach working registers
// - direct mode moves bytes with bank 0
`timescale 1ns/1ps
`default_nettype none
`include "cwr_params.svh"

module cwr_core
  import cwr_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int PC_W   = 11
)
(
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  // decoded instruction
  input  wire logic                step_i,
  input  wire cwr_pkg::cwr_op_type op_i,
  input  wire logic                use_imm_i,
  input  wire logic                to_mem_i,
  input  wire logic [7:0]          addr_i,
  input  wire logic [DATA_W-1:0]   imm_i,
  input  wire logic [2:0]          bit_sel_i,
  input  wire logic [PC_W-1:0]     target_i,
  // data ram
  output logic      [15:0]         ram_raddr_o,
  input  wire logic [DATA_W-1:0]   ram_rdata_i,
  output logic                     ram_wr_o,
  output logic      [15:0]         ram_waddr_o,
  output logic      [DATA_W-1:0]   ram_wdata_o,
  // program rom lookup
  output logic      [PC_W-1:0]     rom_addr_o,
  input  wire logic [15:0]         rom_data_i,
  // reset cause and supply detectors
  input  wire logic [1:0]          reset_cause_i,
  input  wire logic                supply_low_high_level_i,
  input  wire logic                supply_low_mid_level_i,
  input  wire logic                detector_high_option_i,
  input  wire logic                detector_mid_option_i,
  // state
  output logic      [DATA_W-1:0]   acc_o,
  output logic      [DATA_W-1:0]   program_flags_o,
  output logic      [PC_W-1:0]     pc_o
);
  import cwr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] lookup_high_reg;
  logic [DATA_W-1:0] pointer_low_reg;
  logic [DATA_W-1:0] pointer_bank_reg;
  logic [1:0]        reset_cause;
  logic              supply_high_seen;
  logic              supply_mid_seen;
  logic              carry_flag;
  logic              half_carry_flag;
  logic              zero_flag;
  logic [PC_W-1:0]   program_counter;
  logic [DATA_W-1:0] saved_acc;
  logic [DATA_W-1:0] saved_flags;

  wire [DATA_W-1:0] program_flags = {reset_cause, supply_high_seen, supply_mid_seen,
                                     1'b0, carry_flag, half_carry_flag, zero_flag};

  ////////////////////////////////////////////////////////////////////////////
  // adder shared by add, subtract and compare forms: {carry, half carry, sum}
  function automatic logic [DATA_W+1:0] add8(input logic [DATA_W-1:0] x,
                                             input logic [DATA_W-1:0] y,
                                             input logic              cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    hi = {1'b0, x[7:4]} + {1'b0, y[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // operand fetch
  wire is_indirect = addr_i == `CWR_OFS_INDIRECT;
  // pointer pair only forms the address, nothing here updates it
  assign ram_raddr_o = is_indirect ? {pointer_bank_reg, pointer_low_reg}
                                   : {8'h00, addr_i};
  logic [DATA_W-1:0] mem_val;
  always_comb
  begin
    unique case (addr_i)
      `CWR_OFS_LOOKUP_HIGH:   mem_val = lookup_high_reg;
      `CWR_OFS_POINTER_LOW:   mem_val = pointer_low_reg;
      `CWR_OFS_POINTER_BANK:  mem_val = pointer_bank_reg;
      `CWR_OFS_PROGRAM_FLAGS: mem_val = program_flags;
      `CWR_OFS_PC_LOWER:      mem_val = program_counter[7:0];
      `CWR_OFS_PC_UPPER:      mem_val = {5'h00, program_counter[PC_W-1:8]};
      default:                mem_val = ram_rdata_i;
    endcase
  end

  wire [DATA_W-1:0] opnd = use_imm_i ? imm_i : mem_val;
  // destination-first ordering so "sub m,a" is m - a
  wire [DATA_W-1:0] lhs  = to_mem_i ? opnd : acc;
  wire [DATA_W-1:0] rhs  = to_mem_i ? acc : opnd;

  ////////////////////////////////////////////////////////////////////////////
  // alu
  wire               is_sub   = op_i == CWR_OP_SUB || op_i == CWR_OP_SBC || op_i == CWR_OP_COMPARE_SKIP_INSTR;
  wire               add_cin  = (op_i == CWR_OP_ADC) ? carry_flag
                              : (op_i == CWR_OP_SBC) ? carry_flag
                              : is_sub;
  wire [DATA_W+1:0]  sum      = add8(lhs, is_sub ? ~rhs : rhs, add_cin);
  wire [DATA_W+1:0]  cmp      = add8(acc, ~opnd, 1'b1);
  wire [DATA_W-1:0]  inc_val  = opnd + 8'h01;
  wire [DATA_W-1:0]  dec_val  = opnd - 8'h01;

  logic [DATA_W-1:0] result;
  logic              res_carry;
  logic              res_half;
  logic              set_cz;
  logic              set_dc;
  logic              writes;
  logic              skip;
  always_comb
  begin
    result    = opnd;
    res_carry = carry_flag;
    res_half  = half_carry_flag;
    set_cz    = 1'b0;
    set_dc    = 1'b0;
    writes    = 1'b0;
    skip      = 1'b0;
    unique case (op_i)
      CWR_OP_MOV:
      begin
        result = to_mem_i ? (use_imm_i ? imm_i : acc) : opnd;
        writes = 1'b1;
      end
      CWR_OP_ADD, CWR_OP_ADC, CWR_OP_SUB, CWR_OP_SBC:
      begin
        result    = sum[DATA_W-1:0];
        res_carry = sum[DATA_W+1];
        res_half  = sum[DATA_W];
        set_cz    = 1'b1;
        set_dc    = 1'b1;
        writes    = 1'b1;
      end
      CWR_OP_AND, CWR_OP_OR, CWR_OP_XOR:
      begin
        result = (op_i == CWR_OP_AND) ? (acc & opnd)
               : (op_i == CWR_OP_OR)  ? (acc | opnd)
               : (acc ^ opnd);
        set_cz = 1'b1;
        writes = 1'b1;
      end
      CWR_OP_RLC:
      begin
        result    = {opnd[DATA_W-2:0], carry_flag};
        res_carry = opnd[DATA_W-1];
        set_cz    = 1'b1;
        writes    = 1'b1;
      end
      CWR_OP_RRC:
      begin
        result    = {carry_flag, opnd[DATA_W-1:1]};
        res_carry = opnd[0];
        set_cz    = 1'b1;
        writes    = 1'b1;
      end
      CWR_OP_COMPARE_SKIP_INSTR:
      begin
        result    = cmp[DATA_W-1:0];
        res_carry = cmp[DATA_W+1];
        set_cz    = 1'b1;
        skip      = acc == opnd;
      end
      CWR_OP_INC_ACC_SKIP_INSTR:
      begin
        result = inc_val;
        writes = 1'b1;
        skip   = inc_val == 8'h00;
      end
      CWR_OP_DEC_ACC_SKIP_INSTR:
      begin
        result = dec_val;
        writes = 1'b1;
        skip   = dec_val == 8'hff;
      end
      CWR_OP_BIT_CLEAR_SKIP_INSTR: skip = ~opnd[bit_sel_i];
      CWR_OP_BIT_SET_SKIP_INSTR: skip = opnd[bit_sel_i];
      default: result = opnd;
    endcase
  end

  // zero flag is judged on the result before it lands
  wire res_zero = result == 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // write routing
  wire act       = step_i;
  wire in_imm_win = addr_i >= `CWR_IMM_WIN_LO && addr_i <= `CWR_IMM_WIN_HI;
  // immediate stores outside the working registers are dropped
  wire mem_ok    = ~(op_i == CWR_OP_MOV && use_imm_i) || in_imm_win;
  wire wr_mem    = act && writes && to_mem_i && mem_ok;
  // the accumulator has no address, so memory stores never land in it
  wire wr_acc    = act && writes && ~to_mem_i;
  wire wr_lookup = wr_mem && addr_i == `CWR_OFS_LOOKUP_HIGH;
  wire wr_ptr_lo = wr_mem && addr_i == `CWR_OFS_POINTER_LOW;
  wire wr_ptr_bk = wr_mem && addr_i == `CWR_OFS_POINTER_BANK;
  wire wr_flags  = wr_mem && addr_i == `CWR_OFS_PROGRAM_FLAGS;
  wire wr_pcl    = wr_mem && addr_i == `CWR_OFS_PC_LOWER;
  wire wr_pch    = wr_mem && addr_i == `CWR_OFS_PC_UPPER;
  wire wr_sys    = wr_lookup | wr_ptr_lo | wr_ptr_bk | wr_flags | wr_pcl | wr_pch;
  wire wr_ram    = wr_mem && ~wr_sys;
  wire do_rom_lookup_instr   = act && op_i == CWR_OP_ROM_LOOKUP_INSTR;

  ////////////////////////////////////////////////////////////////////////////
  // program counter
  wire [PC_W-1:0] pc_inc   = program_counter + `CWR_PC_STEP;
  wire [PC_W-1:0] pc_skip  = program_counter + `CWR_PC_SKIP;
  wire            pcl_add  = op_i == CWR_OP_ADD || op_i == CWR_OP_ADC;
  // only an upward carry reaches pc_upper; borrows are discarded
  wire [2:0]      pch_step = {2'b00, pcl_add & sum[DATA_W+1]};
  wire [2:0]      pch_cur  = program_counter[PC_W-1:8];
  logic [PC_W-1:0] next_pc;
  always_comb
  begin
    if (!act)
      next_pc = program_counter;
    else if (op_i == CWR_OP_JUMP)
      next_pc = target_i;
    else if (wr_pcl)
      next_pc = {pch_cur + pch_step, result};
    else if (wr_pch)
      next_pc = {result[2:0], program_counter[7:0]} + `CWR_PC_STEP;
    else if (skip)
      next_pc = pc_skip;
    else
      next_pc = pc_inc;
  end

  assign rom_addr_o = PC_W'({pointer_bank_reg, pointer_low_reg});
  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      program_counter <= `CWR_RST_PC;
      acc             <= `CWR_RST_BYTE;
      lookup_high_reg <= `CWR_RST_BYTE;
      pointer_low_reg <= `CWR_RST_BYTE;
      pointer_bank_reg <= `CWR_RST_BYTE;
      saved_acc       <= `CWR_RST_BYTE;
      saved_flags     <= `CWR_RST_BYTE;
    end
    else
    begin
      program_counter <= next_pc;
      if (do_rom_lookup_instr)
      begin
        acc             <= rom_data_i[7:0];
        lookup_high_reg <= rom_data_i[15:8];
      end
      else if (act && op_i == CWR_OP_LOAD)
        acc <= saved_acc;
      else if (wr_acc)
        acc <= result;
      if (wr_lookup)
        lookup_high_reg <= result;
      if (wr_ptr_lo)
        pointer_low_reg <= result;
      if (wr_ptr_bk)
        pointer_bank_reg <= result;
      if (act && op_i == CWR_OP_SAVE)
      begin
        saved_acc   <= acc;
        saved_flags <= program_flags;
      end
    end
  end

  // flags: a store to program_flags wins over the alu update of the same step
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      reset_cause      <= reset_cause_i;
      supply_high_seen <= 1'b0;
      supply_mid_seen  <= 1'b0;
      carry_flag       <= 1'b0;
      half_carry_flag  <= 1'b0;
      zero_flag        <= 1'b0;
    end
    else
    begin
      // detector level is live; it reads 0 when its option is not fitted
      supply_high_seen <= supply_low_high_level_i & detector_high_option_i;
      supply_mid_seen  <= supply_low_mid_level_i & detector_mid_option_i;
      if (act && op_i == CWR_OP_LOAD)
      begin
        reset_cause     <= saved_flags[`CWR_BIT_CAUSE_HI:`CWR_BIT_CAUSE_LO];
        carry_flag      <= saved_flags[`CWR_BIT_CARRY];
        half_carry_flag <= saved_flags[`CWR_BIT_HALF_CARRY];
        zero_flag       <= saved_flags[`CWR_BIT_ZERO];
      end
      else if (wr_flags)
      begin
        reset_cause     <= result[`CWR_BIT_CAUSE_HI:`CWR_BIT_CAUSE_LO];
        carry_flag      <= result[`CWR_BIT_CARRY];
        half_carry_flag <= result[`CWR_BIT_HALF_CARRY];
        zero_flag       <= result[`CWR_BIT_ZERO];
      end
      else if (act)
      begin
        if (set_cz)
        begin
          carry_flag <= res_carry;
          zero_flag  <= res_zero;
        end
        if (set_dc)
          half_carry_flag <= res_half;
      end
    end
  end

  // ram stores are registered so the write strobe never glitches
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ram_wr_o    <= 1'b0;
      ram_waddr_o <= 16'h0000;
      ram_wdata_o <= `CWR_RST_BYTE;
    end
    else
    begin
      ram_wr_o    <= wr_ram;
      ram_waddr_o <= ram_raddr_o;
      ram_wdata_o <= result;
    end
  end

  assign acc_o           = acc;
  assign program_flags_o = program_flags;
  assign pc_o            = program_counter;

endmodule // cwr_core

`default_nettype wire

// ---- test/cwr_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwr_checker
#(
  parameter int DATA_W = 8,
  parameter int PC_W   = 11
)
(
  // clock and reset
  input wire logic                clock_i,
  input wire logic                rst_i,
  // instruction
  input wire logic                step_i,
  input wire cwr_pkg::cwr_op_type op_i,
  input wire logic                use_imm_i,
  input wire logic                to_mem_i,
  input wire logic [7:0]          addr_i,
  input wire logic [DATA_W-1:0]   imm_i,
  input wire logic [PC_W-1:0]     target_i,
  // memories and detectors
  input wire logic [DATA_W-1:0]   ram_rdata_i,
  input wire logic [15:0]         rom_data_i,
  input wire logic [1:0]          reset_cause_i,
  input wire logic                supply_low_high_level_i,
  input wire logic                supply_low_mid_level_i,
  input wire logic                detector_high_option_i,
  input wire logic                detector_mid_option_i,
  // state and ram port
  input wire logic                ram_wr_o,
  input wire logic [15:0]         ram_waddr_o,
  input wire logic [DATA_W-1:0]   ram_wdata_o,
  input wire logic [PC_W-1:0]     rom_addr_o,
  input wire logic [DATA_W-1:0]   acc_o,
  input wire logic [DATA_W-1:0]   program_flags_o,
  input wire logic [PC_W-1:0]     pc_o
);
  import cwr_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_take(cwr_op_type o);
    step_i && op_i == o;
  endsequence
  sequence s_pc_adv(logic [PC_W-1:0] d);
    pc_o == $past(pc_o) + d;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_PC_STEP: assert property (s_take(CWR_OP_NOP) |=> s_pc_adv(11'h001))
    else $error("pc did not advance by one");
  AST_JUMP: assert property (s_take(CWR_OP_JUMP) |=> pc_o == $past(target_i))
    else $error("jump target not loaded");
  AST_CMP_SKIP: assert property (s_take(CWR_OP_COMPARE_SKIP_INSTR) ##0 (use_imm_i && imm_i == acc_o) |=> s_pc_adv(11'h002))
    else $error("equal compare did not skip");
  // system registers all sit above 0x7f, so every low address takes the operand from the ram port
  AST_INC_SKIP: assert property (s_take(CWR_OP_INC_ACC_SKIP_INSTR) ##0 (!use_imm_i && !addr_i[7] && ram_rdata_i == 8'hff) |=> s_pc_adv(11'h002))
    else $error("increment wrap did not skip");
  // reset must hold state even while the default disable is active
  AST_RESET_STATE: assert property (disable iff (1'h0) rst_i |=> pc_o == 11'h000 && acc_o == 8'h00
    && program_flags_o == {$past(reset_cause_i), 6'h00})
    else $error("state wrong after reset");
  AST_RAM_WR: assert property (s_take(CWR_OP_MOV) ##0 (to_mem_i && !use_imm_i && !addr_i[7]) |=>
    ram_wr_o && ram_waddr_o == {8'h00, $past(addr_i)} && ram_wdata_o == $past(acc_o))
    else $error("direct store wrong");
  AST_IMM_REFUSE: assert property (s_take(CWR_OP_MOV) ##0 (use_imm_i && to_mem_i &&
    (addr_i < 8'h80 || addr_i > 8'h87)) |=> !ram_wr_o ##0 s_pc_adv(11'h001))
    else $error("immediate store outside window");
  AST_INDIRECT: assert property (s_take(CWR_OP_MOV) ##0 (addr_i == 8'he7 && !to_mem_i && !use_imm_i) |=>
    acc_o == $past(ram_rdata_i) && rom_addr_o == $past(rom_addr_o))
    else $error("indirect read wrong");
  AST_ROM_LOOKUP_INSTR: assert property (s_take(CWR_OP_ROM_LOOKUP_INSTR) |=> acc_o == $past(rom_data_i[7:0]))
    else $error("lookup low byte wrong");
  // detector bits lag their inputs by one register stage
  AST_DETECT: assert property (1'h1 |=> program_flags_o[5:4] ==
    $past({supply_low_high_level_i & detector_high_option_i, supply_low_mid_level_i & detector_mid_option_i}))
    else $error("detector flag wrong");
endmodule // cwr_checker

bind cwr_core cwr_checker #(.DATA_W(DATA_W), .PC_W(PC_W)) u_checker (.*);
`default_nettype wire

// ---- test/cpu_core_working_registers_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_core_working_registers_test;
  import cwr_pkg::*;
  typedef struct packed {
    cwr_op_type op;
    logic [7:0] a;
    logic [7:0] opnd;
    logic       cin;
    logic [7:0] eacc;
    logic [2:0] ef;
    logic [2:0] mk;
    logic       sk;
  } cwr_row_type;
  logic        clock_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        step_i = 1'h0;
  cwr_op_type  op_i = CWR_OP_NOP;
  logic        use_imm_i = 1'h0;
  logic        to_mem_i = 1'h0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  imm_i = 8'h00;
  logic [2:0]  bit_sel_i = 3'h3;
  logic [10:0] target_i = 11'h000;
  logic [7:0]  ram_rdata_i = 8'h00;
  logic [15:0] rom_data_i = 16'h0000;
  logic [1:0]  reset_cause_i = 2'h2;
  logic        supply_low_high_level_i = 1'h0;
  logic        supply_low_mid_level_i = 1'h0;
  logic        detector_high_option_i = 1'h0;
  logic        detector_mid_option_i = 1'h0;
  logic [15:0] ram_raddr_o, ram_waddr_o, wa;
  logic [7:0]  ram_wdata_o, acc_o, program_flags_o, wd;
  logic [10:0] rom_addr_o, pc_o, p;
  logic        ram_wr_o, wr, m;
  int          err_count = 0, checks = 0, cyc = 0, i;
  cwr_op_type  po[3] = '{CWR_OP_ADD, CWR_OP_SUB, CWR_OP_MOV};
  logic [7:0]  pa[3] = '{8'hf0, 8'h30, 8'h28};
  logic [10:0] pt[3] = '{11'h123, 11'h123, 11'h323};
  logic [10:0] pe[3] = '{11'h213, 11'h1f3, 11'h328};
  logic [7:0]  ia[4] = '{8'h7f, 8'h80, 8'h87, 8'h88};
  logic        iw[4] = '{1'h0, 1'h1, 1'h1, 1'h0};
  cwr_row_type rows[22] = '{
    '{CWR_OP_ADD, 8'hf0, 8'h20, 1'h0, 8'h10, 3'h4, 3'h7, 1'h0},
    '{CWR_OP_ADD, 8'h08, 8'h08, 1'h0, 8'h10, 3'h2, 3'h7, 1'h0},
    '{CWR_OP_ADD, 8'hff, 8'h01, 1'h0, 8'h00, 3'h7, 3'h7, 1'h0},
    '{CWR_OP_ADC, 8'h0f, 8'h00, 1'h1, 8'h10, 3'h2, 3'h7, 1'h0},
    '{CWR_OP_SUB, 8'h05, 8'h03, 1'h0, 8'h02, 3'h6, 3'h7, 1'h0},
    '{CWR_OP_SUB, 8'h03, 8'h05, 1'h0, 8'hfe, 3'h0, 3'h7, 1'h0},
    '{CWR_OP_SBC, 8'h05, 8'h05, 1'h1, 8'h00, 3'h7, 3'h7, 1'h0},
    '{CWR_OP_SBC, 8'h05, 8'h05, 1'h0, 8'hff, 3'h0, 3'h7, 1'h0},
    '{CWR_OP_AND, 8'hf0, 8'h0f, 1'h1, 8'h00, 3'h5, 3'h5, 1'h0},
    '{CWR_OP_XOR, 8'h5a, 8'h5a, 1'h0, 8'h00, 3'h1, 3'h1, 1'h0},
    '{CWR_OP_OR, 8'h50, 8'h0a, 1'h0, 8'h5a, 3'h0, 3'h1, 1'h0},
    '{CWR_OP_RLC, 8'h80, 8'h80, 1'h0, 8'h00, 3'h4, 3'h4, 1'h0},
    '{CWR_OP_RRC, 8'h01, 8'h01, 1'h1, 8'h80, 3'h4, 3'h4, 1'h0},
    '{CWR_OP_COMPARE_SKIP_INSTR, 8'h12, 8'h12, 1'h0, 8'h12, 3'h5, 3'h5, 1'h1},
    '{CWR_OP_COMPARE_SKIP_INSTR, 8'h11, 8'h12, 1'h0, 8'h11, 3'h0, 3'h5, 1'h0},
    '{CWR_OP_INC_ACC_SKIP_INSTR, 8'h00, 8'hff, 1'h0, 8'h00, 3'h0, 3'h0, 1'h1},
    '{CWR_OP_INC_ACC_SKIP_INSTR, 8'h00, 8'hfe, 1'h0, 8'hff, 3'h0, 3'h0, 1'h0},
    '{CWR_OP_DEC_ACC_SKIP_INSTR, 8'h00, 8'h00, 1'h0, 8'hff, 3'h0, 3'h0, 1'h1},
    '{CWR_OP_BIT_SET_SKIP_INSTR, 8'h00, 8'h08, 1'h0, 8'h00, 3'h0, 3'h0, 1'h1},
    '{CWR_OP_BIT_SET_SKIP_INSTR, 8'h00, 8'hf7, 1'h0, 8'h00, 3'h0, 3'h0, 1'h0},
    '{CWR_OP_BIT_CLEAR_SKIP_INSTR, 8'h00, 8'hf7, 1'h0, 8'h00, 3'h0, 3'h0, 1'h1},
    '{CWR_OP_MOV, 8'h00, 8'h3c, 1'h0, 8'h3c, 3'h0, 3'h0, 1'h0}};

  cwr_core dut (.*);

  initial forever #2.5 clock_i = ~clock_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk8(logic [7:0] g, logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t byte %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk16(logic [15:0] g, logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t word %h exp %h", $time, g, e);
    end
  endtask
  // two cycles a step so step_i is never raised and lowered in one time step
  task automatic st(cwr_op_type o, logic ui, logic tm, logic [7:0] ad, logic [7:0] im);
    op_i = o;
    use_imm_i = ui;
    to_mem_i = tm;
    addr_i = ad;
    imm_i = im;
    step_i = 1'h1;
    @(negedge clock_i);
    wr = ram_wr_o;
    wa = ram_waddr_o;
    wd = ram_wdata_o;
    step_i = 1'h0;
    @(negedge clock_i);
  endtask
  task automatic rs(logic [1:0] c, int n);
    reset_cause_i = c;
    rst_i = 1'h1;
    repeat (n) @(negedge clock_i);
    chk16({5'h00, pc_o}, 16'h0000);
    chk8(acc_o, 8'h00);
    chk8(program_flags_o, {c, 6'h00});
    rst_i = 1'h0;
  endtask
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rs(2'h2, 16);
    foreach (rows[k])
    begin
      st(CWR_OP_MOV, 1'h1, 1'h0, 8'h00, {5'h00, rows[k].cin, 2'h0});
      st(CWR_OP_MOV, 1'h0, 1'h1, 8'h86, 8'h00);
      st(CWR_OP_MOV, 1'h1, 1'h0, 8'h00, rows[k].a);
      p = pc_o;
      ram_rdata_i = rows[k].opnd;
      m = rows[k].op inside {CWR_OP_INC_ACC_SKIP_INSTR, CWR_OP_DEC_ACC_SKIP_INSTR, CWR_OP_BIT_CLEAR_SKIP_INSTR, CWR_OP_BIT_SET_SKIP_INSTR, CWR_OP_MOV};
      st(rows[k].op, !m, 1'h0, 8'h10, rows[k].opnd);
      chk8(acc_o, rows[k].eacc);
      chk8({5'h00, program_flags_o[2:0] & rows[k].mk}, {5'h00, rows[k].ef});
      chk16({5'h00, pc_o}, {5'h00, p + (rows[k].sk ? 11'h002 : 11'h001)});
    end
    for (i = 0; i < 4; i++)
      rs(i[1:0], 2);
    target_i = 11'h7fe;
    st(CWR_OP_JUMP, 1'h0, 1'h0, 8'h00, 8'h00);
    chk16({5'h00, pc_o}, 16'h07fe);
    st(CWR_OP_NOP, 1'h0, 1'h0, 8'h00, 8'h00);
    st(CWR_OP_NOP, 1'h0, 1'h0, 8'h00, 8'h00);
    chk16({5'h00, pc_o}, 16'h0000);
    for (i = 0; i < 3; i++)
    begin
      st(CWR_OP_MOV, 1'h1, 1'h0, 8'h00, pa[i]);
      target_i = pt[i];
      st(CWR_OP_JUMP, 1'h0, 1'h0, 8'h00, 8'h00);
      st(po[i], 1'h0, 1'h1, 8'hce, 8'h00);
      chk16({5'h00, pc_o}, {5'h00, pe[i]});
    end
    // a store to pc_upper keeps pc_lower and then counts on by one
    st(CWR_OP_MOV, 1'h1, 1'h0, 8'h00, 8'h02);
    st(CWR_OP_MOV, 1'h0, 1'h1, 8'hcf, 8'h00);
    chk16({5'h00, pc_o}, 16'h022a);
    for (i = 0; i < 4; i++)
    begin
      st(CWR_OP_MOV, 1'h1, 1'h1, ia[i], 8'h33);
      chk8({7'h00, wr}, {7'h00, iw[i]});
    end
    st(CWR_OP_MOV, 1'h1, 1'h0, 8'h00, 8'h5a);
    st(CWR_OP_MOV, 1'h0, 1'h1, 8'h12, 8'h00);
    chk16(wa, 16'h0012);
    chk8(wd, 8'h5a);
    chk8(acc_o, 8'h5a);
    chk16(ram_raddr_o, 16'h0012);
    st(CWR_OP_MOV, 1'h1, 1'h1, 8'h84, 8'h01);
    st(CWR_OP_MOV, 1'h1, 1'h1, 8'h83, 8'h25);
    st(CWR_OP_MOV, 1'h1, 1'h0, 8'he7, 8'h99);
    chk16(ram_raddr_o, 16'h0125);
    st(CWR_OP_MOV, 1'h0, 1'h1, 8'he7, 8'h00);
    chk16(wa, 16'h0125);
    chk16({5'h00, rom_addr_o}, 16'h0125);
    ram_rdata_i = 8'h6b;
    st(CWR_OP_MOV, 1'h0, 1'h0, 8'he7, 8'h00);
    chk8(acc_o, 8'h6b);
    rom_data_i = 16'hbeef;
    st(CWR_OP_ROM_LOOKUP_INSTR, 1'h0, 1'h0, 8'h00, 8'h00);
    chk8(acc_o, 8'hef);
    st(CWR_OP_MOV, 1'h0, 1'h0, 8'h82, 8'h00);
    chk8(acc_o, 8'hbe);
    st(CWR_OP_MOV, 1'h1, 1'h0, 8'h00, 8'hff);
    st(CWR_OP_MOV, 1'h0, 1'h1, 8'h86, 8'h00);
    chk8(program_flags_o, 8'hc7);
    st(CWR_OP_MOV, 1'h1, 1'h0, 8'h00, 8'h5a);
    st(CWR_OP_SAVE, 1'h0, 1'h0, 8'h00, 8'h00);
    st(CWR_OP_MOV, 1'h1, 1'h0, 8'h00, 8'h00);
    st(CWR_OP_MOV, 1'h0, 1'h1, 8'h86, 8'h00);
    st(CWR_OP_LOAD, 1'h0, 1'h0, 8'h00, 8'h00);
    chk8(acc_o, 8'h5a);
    chk8(program_flags_o, 8'hc7);
    for (i = 0; i < 2; i++)
    begin
      ram_rdata_i = i ? 8'h00 : 8'hff;
      p = pc_o;
      st(i ? CWR_OP_DEC_ACC_SKIP_INSTR : CWR_OP_INC_ACC_SKIP_INSTR, 1'h0, 1'h1, 8'h10, 8'h00);
      chk8(wd, i ? 8'hff : 8'h00);
      chk16({5'h00, pc_o}, {5'h00, p + 11'h002});
    end
    // the detector flag only follows the supply when its option strap is set
    for (i = 0; i < 4; i++)
    begin
      supply_low_high_level_i = i[1];
      supply_low_mid_level_i = i[1];
      detector_high_option_i = i[0];
      detector_mid_option_i = i[0];
      repeat (2) @(negedge clock_i);
      chk8({6'h00, program_flags_o[5:4]}, {6'h00, {2{i[1] & i[0]}}});
    end
    report_and_stop();
  end
endmodule // cpu_core_working_registers_test
`default_nettype wire
